// >>> rtl/wcb_consts.vh
`ifndef WCB_CONSTS_VH
`define WCB_CONSTS_VH
// memory classes
`define WCB_CLS_WB        3'h0
`define WCB_CLS_WC        3'h1
`define WCB_CLS_WT        3'h2
`define WCB_CLS_UC        3'h3
`define WCB_CLS_WP        3'h4
// bus write command kinds
`define WCB_CMD_QUAD      2'h0
`define WCB_CMD_LONG      2'h1
`define WCB_CMD_BYTE      2'h2
// open-buffer mode
`define WCB_MODE_NONE     2'h0
`define WCB_MODE_WC       2'h1
`define WCB_MODE_WT       2'h2
// geometry
`define WCB_LINE_BYTES    64
`define WCB_OFS_W         6
`define WCB_QW_BYTES      8
`define WCB_QW_COUNT      8
`define WCB_QW_LAST       3'h7
`define WCB_BYTE_LAST     3'h7
// write-through timeout, processor clocks
`define WCB_WT_TIMEOUT    5'h10
`endif

// >>> rtl/wcb_line_mem.v
`include "wcb_consts.vh"
// line data store: byte-enabled write, registered quadword read
module wcb_line_mem #(
  parameter QWORDS = 8
) (
  input  wire        clk,
  input  wire        we,
  input  wire [2:0]  wr_qw,
  input  wire [7:0]  wr_be,
  input  wire [63:0] wr_data,
  input  wire [2:0]  rd_qw,
  output reg  [63:0] rd_data
);
  reg [63:0] mem [0:QWORDS-1];
  integer i;
  always @(posedge clk) begin
    if (we) begin
      for (i = 0; i < 8; i = i + 1) begin
        if (wr_be[i])
          mem[wr_qw][i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
    rd_data <= mem[rd_qw];
  end
endmodule

// >>> rtl/wcb_top.v
// Notes on behaviour
// - merge stores inside one aligned 64-byte line
// - combinable class accepts any order until full
// - write-through merges contiguous ascending within quadword
// - uncached and protected stores never merge
// - non-write-back store to other line closes
// - one open buffer; closed never reopens
// - port input or output closes combining
// - serializing operations close combining
// - flush forces open buffer to complete
// - close before lock; locked stores may merge
// - uncached read closes; combinable read on match
// - class change between combinable and write-through closes
// - close when all 64 bytes valid
// - write-through closes 16 clocks after last store
// - straddling store: only the lower quadword part is kept; write-through closes
// - accessed or dirty flag update closes combining
// - send to bus only after closing
// - all quadwords full or empty: one quadword command
// - all longwords full or empty: per-half longword commands
// - else per quadword: quad, longword or byte command
`include "wcb_consts.vh"
module wcb_top #(
  parameter TIMEOUT = 16
) (
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire        ST_VALID,
  output wire        ST_READY,
  input  wire [2:0]  ST_CLASS,
  input  wire [31:0] ST_ADDR,
  input  wire [3:0]  ST_SIZE,
  input  wire [63:0] ST_DATA,
  input  wire        PORT_IO,
  input  wire        SERIALIZE,
  input  wire        FLUSH,
  input  wire        LOCK_START,
  input  wire        RD_VALID,
  input  wire [2:0]  RD_CLASS,
  input  wire [31:0] RD_ADDR,
  input  wire        TLB_AD_SET,
  output wire        LOCK_READY,
  output reg         CMD_VALID,
  input  wire        CMD_READY,
  output reg  [1:0]  CMD_KIND,
  output reg  [25:0] CMD_LINE,
  output reg  [2:0]  CMD_QW,
  output reg  [7:0]  CMD_MASK,
  output wire [63:0] CMD_DATA,
  output reg         CMD_LAST,
  output wire        OPEN,
  output wire [1:0]  OPEN_MODE
);
  ////////////////////////////////////////////////////////////////////////
  // state
  localparam S_IDLE = 3'h1;
  localparam S_OPEN = 3'h2;
  localparam S_SEND = 3'h4;

  reg  [2:0]  state;
  reg  [1:0]  mode;
  reg  [25:0] line;
  reg  [63:0] valid;
  reg  [5:0]  wt_next;
  reg  [4:0]  wt_timer;
  reg  [2:0]  scan_qw;
  reg         half;
  reg         mem_rd_pend;
  reg  [2:0]  rd_qw;
  reg  [2:0]  pass;

  ////////////////////////////////////////////////////////////////////////
  // store decode
  wire [5:0]  st_ofs  = ST_ADDR[5:0];
  wire [25:0] st_line = ST_ADDR[31:6];
  wire [7:0]  size_m  = (8'h01 << ST_SIZE) - 8'h01;
  // 16-bit lane mask across a quadword pair; upper byte is the next quadword
  wire [15:0] lanes   = {8'h00, size_m} << ST_ADDR[2:0];
  wire        straddle = |lanes[15:8];
  wire [7:0]  lo_be   = lanes[7:0];
  wire [63:0] lo_bits = {56'h0, lo_be} << {ST_ADDR[5:3], 3'h0};
  wire [5:0]  end_ofs = st_ofs + {2'h0, ST_SIZE} - 6'h01;
  wire        is_wc   = ST_CLASS == `WCB_CLS_WC;
  wire        is_wt   = ST_CLASS == `WCB_CLS_WT;
  wire        is_wb   = ST_CLASS == `WCB_CLS_WB;
  wire        is_open = state == S_OPEN;
  wire        same_ln = st_line == line;

  // events that end merging without a store
  wire rd_close = RD_VALID & ((RD_CLASS == `WCB_CLS_UC) |
                  ((RD_CLASS == `WCB_CLS_WC) & (RD_ADDR[31:6] == line) &
                   (|valid)));
  // each completion event on its own wire so its source stays traceable
  wire ev_io    = PORT_IO;
  wire ev_ser   = SERIALIZE;
  wire ev_flush = FLUSH;
  wire ev_lock  = LOCK_START;
  wire ev_tlb   = TLB_AD_SET;
  wire tmo      = (mode == `WCB_MODE_WT) & ({27'h0, wt_timer} == TIMEOUT);
  wire ev_close = ev_io | ev_ser | ev_flush | ev_lock | ev_tlb | rd_close | tmo;

  // a store merges only into a matching open buffer
  wire wt_ok  = (mode == `WCB_MODE_WT) & is_wt & same_ln &
                (st_ofs == wt_next) & (st_ofs[5:3] == wt_next[5:3]);
  wire wc_ok  = (mode == `WCB_MODE_WC) & is_wc & same_ln;
  wire merge  = is_open & (wc_ok | wt_ok);
  // reasons a non-write-back store cannot join the open buffer
  wire cls_swap  = ((mode == `WCB_MODE_WT) & is_wc) | ((mode == `WCB_MODE_WC) & is_wt);
  wire cls_nomrg = ~is_wc & ~is_wt;
  wire wc_other  = (mode == `WCB_MODE_WC) & is_wc & ~same_ln;
  wire wt_break  = (mode == `WCB_MODE_WT) & is_wt & ~wt_ok;
  wire st_close  = ST_VALID & ~is_wb & is_open & (cls_swap | cls_nomrg | wc_other | wt_break);

  // store taken only when no buffer is draining and no close is pending
  assign ST_READY   = (state != S_SEND) & ~ev_close & ~st_close;
  assign LOCK_READY = state != S_OPEN;
  wire   st_take    = ST_VALID & ST_READY & ~is_wb;
  wire [63:0] new_valid = valid | lo_bits;
  wire wt_fill7 = is_wt & (straddle | (end_ofs[2:0] == `WCB_BYTE_LAST));

  assign OPEN      = is_open;
  assign OPEN_MODE = mode;

  ////////////////////////////////////////////////////////////////////////
  // command selection
  wire [7:0]  qw_full;
  wire [7:0]  qw_any;
  wire [15:0] lw_full;
  wire [15:0] lw_any;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : qw_g
      assign qw_full[g]     = &valid[g*8 +: 8];
      assign qw_any[g]      = |valid[g*8 +: 8];
      assign lw_full[2*g]   = &valid[g*8 +: 4];
      assign lw_full[2*g+1] = &valid[g*8+4 +: 4];
      assign lw_any[2*g]    = |valid[g*8 +: 4];
      assign lw_any[2*g+1]  = |valid[g*8+4 +: 4];
    end
  endgenerate
  wire all_qw = (qw_full | ~qw_any) == 8'hFF;
  wire all_lw = (lw_full | ~lw_any) == 16'hFFFF;
  wire [7:0] cur_v = valid[{scan_qw, 3'h0} +: 8];
  wire cur_lo_lw = cur_v == 8'h0F;
  wire cur_hi_lw = cur_v == 8'hF0;
  wire [7:0] later = qw_any & ~((8'h02 << scan_qw) - 8'h01);
  wire       more  = |later;
  reg  [2:0] nxt_qw;
  integer k;
  always @* begin
    nxt_qw = `WCB_QW_LAST;
    for (k = 7; k >= 0; k = k - 1) begin
      if (later[k])
        nxt_qw = k[2:0];
    end
  end
  reg [2:0] first_qw;
  always @* begin
    first_qw = `WCB_QW_LAST;
    for (k = 7; k >= 0; k = k - 1) begin
      if (qw_any[k])
        first_qw = k[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next command, chosen from the alignment of the valid bytes
  reg [1:0] next_kind;
  reg [2:0] next_qw;
  reg [7:0] next_mask;
  reg       next_last;
  always @* begin
    next_kind = `WCB_CMD_BYTE;
    next_qw   = scan_qw;
    next_mask = cur_v;
    next_last = ~more;
    if (all_qw) begin
      next_kind = `WCB_CMD_QUAD;
      next_qw   = 3'h0;
      next_mask = qw_any;
      next_last = 1'b1;
    end else if (all_lw) begin
      next_kind = `WCB_CMD_LONG;
      next_qw   = {half, 2'h0};
      next_mask = half ? lw_any[15:8] : lw_any[7:0];
      next_last = half | ~(|lw_any[15:8]);
    end else if (qw_full[scan_qw]) begin
      next_kind = `WCB_CMD_QUAD;
      next_mask = 8'h01;
    end else if (cur_lo_lw | cur_hi_lw) begin
      // a single aligned longword asserts one mask bit
      next_kind = `WCB_CMD_LONG;
      next_mask = cur_lo_lw ? 8'h01 : 8'h02;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and mode sequencing
  reg  [2:0] next_state;
  reg  [1:0] next_mode;
  wire       full_line  = new_valid == 64'hFFFFFFFFFFFFFFFF;
  wire       full_first = lo_bits == 64'hFFFFFFFFFFFFFFFF;
  always @* begin
    next_state = state;
    next_mode  = mode;
    case (state)
      S_IDLE: begin
        if (st_take) begin
          if (is_wt & ~wt_fill7) begin
            next_state = S_OPEN;
            next_mode  = `WCB_MODE_WT;
          end else if (is_wc & ~full_first) begin
            next_state = S_OPEN;
            next_mode  = `WCB_MODE_WC;
          end else begin
            // uncached, protected, full line or byte-7 fill go out alone
            next_state = S_SEND;
            next_mode  = `WCB_MODE_NONE;
          end
        end
      end
      S_OPEN: begin
        // a closed buffer only drains; it never returns to merging
        if (ev_close | st_close | (st_take & (full_line | wt_fill7))) begin
          next_state = S_SEND;
          next_mode  = `WCB_MODE_NONE;
        end
      end
      S_SEND: begin
        if (CMD_VALID & CMD_READY & CMD_LAST)
          next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
        next_mode  = `WCB_MODE_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // line data
  wcb_line_mem #(.QWORDS(`WCB_QW_COUNT)) u_mem (
    .clk     (CLOCK),
    .we      (st_take),
    .wr_qw   (ST_ADDR[5:3]),
    .wr_be   (lo_be),
    .wr_data (ST_DATA << {ST_ADDR[2:0], 3'h0}),
    .rd_qw   (rd_qw),
    .rd_data (CMD_DATA)
  );

  ////////////////////////////////////////////////////////////////////////
  // control
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state       <= S_IDLE;
      mode        <= `WCB_MODE_NONE;
      line        <= 26'h0;
      valid       <= 64'h0;
      wt_next     <= 6'h0;
      wt_timer    <= 5'h0;
      scan_qw     <= 3'h0;
      half        <= 1'b0;
      mem_rd_pend <= 1'b0;
      rd_qw       <= 3'h0;
      pass        <= 3'h0;
      CMD_VALID   <= 1'b0;
      CMD_KIND    <= `WCB_CMD_QUAD;
      CMD_LINE    <= 26'h0;
      CMD_QW      <= 3'h0;
      CMD_MASK    <= 8'h00;
      CMD_LAST    <= 1'b0;
    end else begin
      state <= next_state;
      mode  <= next_mode;
      case (state)
        S_IDLE: begin
          if (st_take) begin
            line     <= st_line;
            valid    <= lo_bits;
            wt_next  <= end_ofs + 6'h01;
            wt_timer <= 5'h0;
          end
        end
        S_OPEN: begin
          if (st_take & merge) begin
            valid    <= new_valid;
            wt_next  <= end_ofs + 6'h01;
            wt_timer <= 5'h0;
          end else if (mode == `WCB_MODE_WT) begin
            wt_timer <= wt_timer + 5'h01;
          end
        end
        S_SEND: begin
          if (~CMD_VALID & ~mem_rd_pend) begin
            mem_rd_pend <= 1'b1;
            rd_qw       <= (pass == 3'h0) ? first_qw : scan_qw;
          end else if (mem_rd_pend & ~CMD_VALID) begin
            mem_rd_pend <= 1'b0;
            CMD_VALID   <= 1'b1;
            CMD_LINE    <= line;
            CMD_KIND    <= next_kind;
            CMD_QW      <= next_qw;
            CMD_MASK    <= next_mask;
            CMD_LAST    <= next_last;
          end else if (CMD_VALID & CMD_READY) begin
            CMD_VALID <= 1'b0;
            if (CMD_LAST) begin
              valid   <= 64'h0;
              half    <= 1'b0;
              pass    <= 3'h0;
              scan_qw <= 3'h0;
            end else begin
              pass    <= 3'h1;
              half    <= 1'b1;
              scan_qw <= nxt_qw;
              if (pass == 3'h0 & ~all_qw & ~all_lw)
                scan_qw <= nxt_qw;
            end
          end
          if (pass == 3'h0 & ~mem_rd_pend & ~CMD_VALID & ~all_lw & ~all_qw)
            scan_qw <= first_qw;
          else if (pass == 3'h0 & ~mem_rd_pend & ~CMD_VALID & all_lw)
            half <= ~(|lw_any[7:0]);
        end
        default: begin
          valid <= 64'h0;
        end
      endcase
    end
  end
endmodule

// >>> test/tb_top.sv
`include "wcb_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [2:0] WC = `WCB_CLS_WC, WT = `WCB_CLS_WT, UC = `WCB_CLS_UC, WB = `WCB_CLS_WB;
  localparam [1:0] QD = `WCB_CMD_QUAD, LW = `WCB_CMD_LONG, BY = `WCB_CMD_BYTE;
  reg         CLOCK, NRST, ST_VALID, RD_VALID;
  reg  [2:0]  ST_CLASS, RD_CLASS;
  reg  [31:0] ST_ADDR, RD_ADDR;
  reg  [3:0]  ST_SIZE, slow;
  reg  [63:0] ST_DATA;
  reg  [4:0]  ev;
  reg  [25:0] ln;
  wire        ST_READY, LOCK_READY, CMD_VALID, CMD_READY, CMD_LAST, OPEN;
  wire [1:0]  CMD_KIND, OPEN_MODE;
  wire [25:0] CMD_LINE;
  wire [2:0]  CMD_QW;
  wire [7:0]  CMD_MASK;
  wire [63:0] CMD_DATA;
  integer     num_errors, checks_done, i;
  wcb_top DUT (.CLOCK(CLOCK), .NRST(NRST), .ST_VALID(ST_VALID), .ST_READY(ST_READY), .ST_CLASS(ST_CLASS),
    .ST_ADDR(ST_ADDR), .ST_SIZE(ST_SIZE), .ST_DATA(ST_DATA), .PORT_IO(ev[4]), .SERIALIZE(ev[3]), .FLUSH(ev[2]),
    .LOCK_START(ev[1]), .TLB_AD_SET(ev[0]), .RD_VALID(RD_VALID), .RD_CLASS(RD_CLASS), .RD_ADDR(RD_ADDR),
    .LOCK_READY(LOCK_READY), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_KIND(CMD_KIND),
    .CMD_LINE(CMD_LINE), .CMD_QW(CMD_QW), .CMD_MASK(CMD_MASK), .CMD_DATA(CMD_DATA), .CMD_LAST(CMD_LAST),
    .OPEN(OPEN), .OPEN_MODE(OPEN_MODE));
  wcb_bus_model bus (.clk(CLOCK), .nrst(NRST), .cmd_valid(CMD_VALID), .slow(slow), .cmd_ready(CMD_READY));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] g, input logic [63:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge CLOCK);
      #1;
    end
  endtask
  task give_up;
    begin
      num_errors = num_errors + 1;
      stop_test;
    end
  endtask
  task st(input [2:0] c, input [31:0] a, input [3:0] s, input [63:0] d);
    integer n;
    begin
      {ST_VALID, ST_CLASS, ST_ADDR, ST_SIZE, ST_DATA} = {1'b1, c, a, s, d};
      n = 0;
      #1;
      while (ST_READY !== 1'b1 && n < 200) begin
        tick;
        #1;
        n = n + 1;
      end
      if (n == 200) give_up;
      tick;
      ST_VALID = 1'b0;
      tick;
    end
  endtask
  task pulse(input [4:0] e);
    begin
      ev = e;
      tick;
      ev = 5'h00;
    end
  endtask
  task rd(input [2:0] c, input [31:0] a);
    begin
      {RD_VALID, RD_CLASS, RD_ADDR} = {1'b1, c, a};
      tick;
      RD_VALID = 1'b0;
      tick;
    end
  endtask
  // zero mask or zero data means that field is not compared
  task cmd(input [1:0] k, input [2:0] q, input [7:0] m, input l, input [7:0] d);
    integer n;
    begin
      n = 0;
      while ((CMD_VALID && CMD_READY) !== 1'b1 && n < 200) begin
        tick;
        n = n + 1;
      end
      if (n == 200) give_up;
      chk({CMD_KIND, CMD_QW, CMD_LAST, (m != 8'h00) ? CMD_MASK : 8'h00, CMD_LINE}, {k, q, l, m, ln});
      chk((d != 8'h00) ? CMD_DATA[7:0] : 8'h00, d);
      tick;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    {NRST, ST_VALID, RD_VALID, ST_CLASS, RD_CLASS, ST_ADDR, RD_ADDR, ST_SIZE, ST_DATA, ev} = 0;
    {num_errors, checks_done, slow, ln} = 0;
    repeat (6) @(posedge CLOCK);
    #1 NRST = 1'b1;
    tick;
    chk({OPEN, CMD_VALID}, 2'b00);
    for (i = 0; i < 6; i = i + 1) begin
      st(WC, 8 * i, 1, 64'h11);
      st(WC, 8 * i, 1, 64'h50 + i);
      chk(OPEN, 1'b1);
      if (i == 5) begin
        rd(WC, 32'h40);
        chk(OPEN, 1'b1);
        rd(UC, 32'h0);
      end else pulse(5'h01 << i);
      cmd(BY, i, 8'h01, 1'b1, 8'h50 + i);
    end
    slow = 4'h3;
    ln = 26'h1;
    for (i = 0; i < 8; i = i + 1) st(WC, 32'h40 + 8 * (7 - i), 8, 64'h0);
    cmd(QD, 0, 8'hFF, 1'b1, 8'h00);
    ln = 26'h2;
    st(WC, 32'hA8, 8, 64'h0);
    st(WC, 32'h90, 8, 64'h0);
    repeat (40) tick;
    chk(OPEN, 1'b1);
    rd(WC, 32'h83);
    cmd(QD, 0, 8'h24, 1'b1, 8'h00);
    ln = 26'h3;
    st(WC, 32'hC0, 4, 64'h0);
    st(WC, 32'hF4, 4, 64'h0);
    pulse(5'h04);
    cmd(LW, 0, 8'h01, 1'b0, 8'h00);
    cmd(LW, 4, 8'h20, 1'b1, 8'h00);
    ln = 26'h4;
    st(WT, 32'h102, 2, 64'h0);
    st(WT, 32'h104, 2, 64'h0);
    chk(OPEN_MODE, `WCB_MODE_WT);
    cmd(BY, 0, 8'h3C, 1'b1, 8'h00);
    st(WT, 32'h101, 1, 64'h0);
    fork
      st(WT, 32'h105, 1, 64'h0);
      cmd(BY, 0, 8'h02, 1'b1, 8'h00);
    join
    fork
      st(WT, 32'h106, 2, 64'h0);
      cmd(BY, 0, 8'hE0, 1'b1, 8'h00);
    join
    fork
      st(WT, 32'h106, 4, 64'h0);
      cmd(BY, 0, 8'hC0, 1'b1, 8'h00);
    join
    st(WT, 32'h108, 2, 64'h0);
    chk(OPEN_MODE, `WCB_MODE_WT);
    pulse(5'h04);
    cmd(BY, 1, 8'h03, 1'b1, 8'h00);
    ln = 26'h5;
    st(WC, 32'h140, 1, 64'h0);
    fork
      st(WT, 32'h148, 1, 64'h0);
      cmd(BY, 0, 8'h01, 1'b1, 8'h00);
    join
    chk(OPEN_MODE, `WCB_MODE_WT);
    pulse(5'h04);
    cmd(BY, 1, 8'h01, 1'b1, 8'h00);
    ln = 26'h6;
    st(WC, 32'h180, 1, 64'h0);
    st(WB, 32'h1C0, 1, 64'h0);
    chk(OPEN, 1'b1);
    fork
      st(WC, 32'h1C0, 1, 64'h0);
      cmd(BY, 0, 8'h01, 1'b1, 8'h00);
    join
    ln = 26'h7;
    pulse(5'h04);
    cmd(BY, 0, 8'h01, 1'b1, 8'h00);
    ln = 26'h8;
    fork
      st(UC, 32'h200, 1, 64'h0);
      cmd(BY, 0, 8'h01, 1'b1, 8'h00);
    join
    fork
      st(UC, 32'h201, 1, 64'h0);
      cmd(BY, 0, 8'h02, 1'b1, 8'h00);
    join
    ln = 26'h9;
    st(WC, 32'h248, 8, 64'h77);
    st(WC, 32'h258, 4, 64'h0);
    st(WC, 32'h271, 1, 64'h0);
    pulse(5'h04);
    cmd(QD, 1, 8'h01, 1'b0, 8'h77);
    cmd(LW, 3, 8'h01, 1'b0, 8'h00);
    cmd(BY, 6, 8'h02, 1'b1, 8'h00);
    stop_test;
  end
endmodule
bind wcb_top wcb_props #(.TIMEOUT(TIMEOUT)) props (.CLOCK(CLOCK), .NRST(NRST), .ST_VALID(ST_VALID),
  .ST_READY(ST_READY), .PORT_IO(PORT_IO), .SERIALIZE(SERIALIZE), .FLUSH(FLUSH), .LOCK_START(LOCK_START),
  .TLB_AD_SET(TLB_AD_SET), .LOCK_READY(LOCK_READY), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .CMD_KIND(CMD_KIND), .CMD_MASK(CMD_MASK), .OPEN(OPEN), .OPEN_MODE(OPEN_MODE));

// >>> test/wcb_bus_model.sv
module wcb_bus_model (
  input wire       clk,
  input wire       nrst,
  input wire       cmd_valid,
  input wire [3:0] slow,
  output reg       cmd_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] wait_cnt;
  // accepts after slow cycles, drops ready after each accept
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (cmd_valid && !cmd_ready && wait_cnt >= slow) begin
      cmd_ready <= 1'b1;
      wait_cnt <= 4'h0;
    end else if (cmd_valid && !cmd_ready) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      cmd_ready <= 1'b0;
    end
  end
endmodule

// >>> test/wcb_props.sv
module wcb_props #(
  parameter TIMEOUT = 16
) (
  input wire       CLOCK,
  input wire       NRST,
  input wire       ST_VALID,
  input wire       ST_READY,
  input wire       PORT_IO,
  input wire       SERIALIZE,
  input wire       FLUSH,
  input wire       LOCK_START,
  input wire       TLB_AD_SET,
  input wire       LOCK_READY,
  input wire       CMD_VALID,
  input wire       CMD_READY,
  input wire [1:0] CMD_KIND,
  input wire [7:0] CMD_MASK,
  input wire       OPEN,
  input wire [1:0] OPEN_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic [7:0] idle;
  // cycles spent in write-through merging with no store taken
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) idle <= 8'h00;
    else idle <= (OPEN_MODE == 2'h2 && !(ST_VALID && ST_READY)) ? idle + 8'h01 : 8'h00;
  end
  sequence s_take; CMD_VALID && CMD_READY; endsequence
  sequence s_wait; CMD_VALID && !CMD_READY; endsequence
  a_lock_gate: assert property (LOCK_READY == !OPEN) else $error("lock gate wrong");
  a_cmd_hold: assert property (s_wait |=> CMD_VALID && $stable(CMD_KIND) && $stable(CMD_MASK))
    else $error("command changed before accept");
  a_drain_closed: assert property (CMD_VALID |-> !OPEN && !ST_READY) else $error("open while draining");
  a_cmd_gap: assert property (s_take |=> !CMD_VALID) else $error("no gap after command");
  a_flush_close: assert property (FLUSH && OPEN |=> !OPEN) else $error("flush left buffer open");
  a_io_close: assert property (PORT_IO && OPEN |=> !OPEN) else $error("port access left open");
  a_serial_close: assert property (SERIALIZE && OPEN |=> !OPEN) else $error("serialize left open");
  a_lock_close: assert property (LOCK_START && OPEN |=> !OPEN) else $error("lock left open");
  a_tlb_close: assert property (TLB_AD_SET && OPEN |=> !OPEN) else $error("flag update left open");
  a_wt_timeout: assert property (idle <= TIMEOUT + 1) else $error("write-through timeout missed");
endmodule
